//--- src/hisel_pkg.sv
// Shared constants and types for the host interface select block.
// Assumes a 125 MHz system clock; the link side runs on its own clock.
package hisel_pkg;
    localparam int CLK_MHZ = 125;
    localparam int RTC_HZ = 32768;
    localparam int USB_BPS = 12000000;
    localparam int CNT_W = 12;
    localparam int BAUD_W = 16;
    localparam logic [15:0] BAUD_DIV_RST = 16'h0364;
    localparam logic [CNT_W-1:0] THRESH_RST = 12'h001;
    localparam logic TXR_EN_RST = 1'b0;
    localparam logic TXR_POL_RST = 1'b1;
    localparam int SYNC_STAGES = 2;
    localparam logic [1:0] CFG_SRC_DFLT = 2'h0;
    localparam logic [1:0] CFG_SRC_STORE = 2'h1;
    localparam logic [1:0] CFG_SRC_LIVE = 2'h2;

    typedef enum logic [2:0]
    {
        HISEL_MODE_UART_I2C = 3'b001,
        HISEL_MODE_SPI = 3'b010,
        HISEL_MODE_IDLE = 3'b100
    } hisel_mode_t;

    typedef enum logic [2:0]
    {
        HISEL_PWR_MAIN = 3'b001,
        HISEL_PWR_BACKUP = 3'b010,
        HISEL_PWR_OFF = 3'b100
    } hisel_pwr_t;
endpackage : hisel_pkg

//--- src/hisel_sync.sv
// Two-flop level synchroniser, generic width.
// Assumes the input is a level that holds for several destination cycles.
`timescale 1ns/100ps
module hisel_sync
#(
    parameter int W = 1
)
(
    // Destination domain
    input wire logic clk,
    input wire logic rst,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_r <= '0;
            q_r <= '0;
        end
        else
        begin
            meta_r <= d;
            q_r <= meta_r;
        end
    end

    assign q = q_r;
endmodule : hisel_sync

//--- src/hisel_store.sv
// Battery-backed configuration store: holds saved words while backup supply lasts.
// Assumes valid flag is cleared only when the backup supply drops.
`timescale 1ns/100ps
module hisel_store
#(
    parameter int W = 32
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic bkp_lost,
    // Save port
    input wire logic save,
    input wire logic [W-1:0] wdata,
    // Restore port
    output logic [W-1:0] rdata,
    output logic valid
);
    logic [W-1:0] mem_r;
    logic [W-1:0] rdata_r;
    logic valid_r;

    // Contents survive main reset, lost only with backup supply
    always_ff @(posedge clk)
    begin
        if (save)
            mem_r <= wdata;
        rdata_r <= mem_r;
    end

    always_ff @(posedge clk)
    begin
        if (bkp_lost)
            valid_r <= 1'b0;
        else if (save)
            valid_r <= 1'b1;
    end

    assign rdata = rdata_r;
    assign valid = valid_r;
endmodule : hisel_store

//--- src/hisel_top.sv
// Host interface selection, transmit-pending indicator and backup-domain control.
// Assumes CLK at 125 MHz, LINK_CLK from the two-wire/four-wire host link side.
// Contract
// - Live config lost at reset unless saved
// - Saved config kept while backup supply holds
// - No backup supply means cold start
// - Main supply feeds clock and store
// - Clock counts 32 kHz ticks in backup
// - Serial port: no flow control, baud only
// - Full-speed device, pull-up on positive line
// - Self-powered only, no bus power
// - Two-wire port is target only
// - Two-wire port follows fast-mode protocol
// - Four-wire port off by default
// - Select pin grounded enables four-wire port
// - Indicator active when output data waits
// - Polarity and byte threshold configurable
// - Indicator routable onto serial transmit pin, only while the serial port is off (four-wire mode)
// - Indicator disabled at reset; a saved enable is restored on warm start
// - Select pin open enables serial and two-wire
`timescale 1ns/100ps
module hisel_top
    import hisel_pkg::*;
#(
    parameter int CW = hisel_pkg::CNT_W
)
(
    // System clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Link clock domain
    input wire logic LINK_CLK,
    input wire logic LINK_RST,
    // Power supervision pins
    input wire logic MAIN_PWR_OK,
    input wire logic BKP_PWR_OK,
    output logic BKP_ISOLATE,
    output logic RTC_FROM_MAIN,
    output logic COLD_START,
    output logic [1:0] CFG_SOURCE,
    // Real-time clock
    input wire logic RTC_TICK,
    output logic [31:0] RTC_COUNT,
    // Interface select strap
    input wire logic IF_SEL_N,
    output logic [2:0] IF_MODE,
    output logic SERIAL_EN,
    output logic TWO_WIRE_EN,
    output logic FOUR_WIRE_EN,
    // Live configuration
    input wire logic CFG_WR,
    input wire logic [hisel_pkg::BAUD_W-1:0] CFG_BAUD_DIV,
    input wire logic CFG_TXR_EN,
    input wire logic CFG_TXR_POL,
    input wire logic CFG_TXR_ON_TXD,
    input wire logic [CW-1:0] CFG_TXR_THRESH,
    input wire logic CFG_SAVE,
    output logic [hisel_pkg::BAUD_W-1:0] BAUD_DIV,
    // Output byte buffer level
    input wire logic BYTE_PUSH,
    input wire logic LINK_BYTE_POP,
    output logic [CW-1:0] TX_COUNT,
    // Serial transmit pin
    input wire logic SER_TXD_DATA,
    output logic TXD_PIN,
    output logic TXR_PIN,
    // Two-wire target pins
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    output logic SCL_OUT,
    output logic SCL_OE,
    input wire logic TWO_WIRE_ACK,
    // USB device
    input wire logic USB_VDD_OK,
    output logic USB_DP_PULLUP,
    output logic USB_SELF_POWERED,
    output logic USB_FULL_SPEED
);
    import hisel_pkg::*;

    localparam int CFG_W = BAUD_W + CW + 3;

    // Pin synchronisers keep no reset so supply state survives RST
    logic sel_n_s;
    logic main_ok_s;
    logic bkp_ok_s;
    logic rtc_tick_s;
    logic usb_ok_s;
    logic sda_s;

    hisel_sync #(.W(6)) u_sync
    (
        .clk(CLK),
        .rst(1'b0),
        .d({IF_SEL_N, MAIN_PWR_OK, BKP_PWR_OK, RTC_TICK, USB_VDD_OK, SDA_IN}),
        .q({sel_n_s, main_ok_s, bkp_ok_s, rtc_tick_s, usb_ok_s, sda_s})
    );

    // Strap capture after reset release
    logic strap_done_r;
    logic strap_done_nxt;
    hisel_mode_t mode_r;
    hisel_mode_t mode_nxt;
    logic sync_warm_r;
    logic [1:0] warm_cnt_r;

    always_ff @(posedge CLK)
    begin
        if (RST)
            warm_cnt_r <= 2'h0;
        else if (warm_cnt_r != 2'h3)
            warm_cnt_r <= warm_cnt_r + 2'h1;
    end

    assign sync_warm_r = (warm_cnt_r == 2'h3);
    assign strap_done_nxt = strap_done_r | sync_warm_r;

    assign mode_nxt = strap_done_r ? mode_r :
                      !sync_warm_r ? HISEL_MODE_IDLE :
                      sel_n_s ? HISEL_MODE_UART_I2C : HISEL_MODE_SPI;

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            strap_done_r <= 1'b0;
            mode_r <= HISEL_MODE_IDLE;
        end
        else
        begin
            strap_done_r <= strap_done_nxt;
            mode_r <= mode_nxt;
        end
    end

    logic four_wire_w;
    logic serial_w;
    assign four_wire_w = (mode_r == HISEL_MODE_SPI);
    assign serial_w = (mode_r == HISEL_MODE_UART_I2C);
    assign IF_MODE = mode_r;
    assign FOUR_WIRE_EN = four_wire_w;
    assign SERIAL_EN = serial_w;
    assign TWO_WIRE_EN = serial_w;

    // Power domain state
    hisel_pwr_t pwr_r;
    hisel_pwr_t pwr_nxt;

    always_comb
    begin
        unique case (pwr_r)
            HISEL_PWR_MAIN:
                pwr_nxt = main_ok_s ? HISEL_PWR_MAIN :
                          bkp_ok_s ? HISEL_PWR_BACKUP : HISEL_PWR_OFF;
            HISEL_PWR_BACKUP:
                pwr_nxt = main_ok_s ? HISEL_PWR_MAIN :
                          bkp_ok_s ? HISEL_PWR_BACKUP : HISEL_PWR_OFF;
            HISEL_PWR_OFF:
                pwr_nxt = main_ok_s ? HISEL_PWR_MAIN : HISEL_PWR_OFF;
            default:
                pwr_nxt = HISEL_PWR_OFF;
        endcase
    end

    // Backup domain ignores RST; an unknown power-up state falls to off
    always_ff @(posedge CLK)
    begin
        pwr_r <= pwr_nxt;
    end

    assign BKP_ISOLATE = main_ok_s;
    assign RTC_FROM_MAIN = main_ok_s;

    // Backup lost when neither supply holds
    logic bkp_lost_w;
    assign bkp_lost_w = (pwr_nxt == HISEL_PWR_OFF);

    logic [31:0] rtc_r;
    logic tick_d_r;
    logic tick_rise_w;
    assign tick_rise_w = rtc_tick_s & ~tick_d_r;

    always_ff @(posedge CLK)
    begin
        tick_d_r <= rtc_tick_s;
        if (bkp_lost_w)
            rtc_r <= 32'h0000_0000;
        else if (tick_rise_w)
            rtc_r <= rtc_r + 32'h0000_0001;
    end

    assign RTC_COUNT = rtc_r;

    // Live configuration registers
    logic [BAUD_W-1:0] baud_r;
    logic txr_en_r;
    logic txr_pol_r;
    logic txr_on_txd_r;
    logic [CW-1:0] thresh_r;
    logic [CFG_W-1:0] store_rd;
    logic store_valid;
    logic [CFG_W-1:0] live_w;
    logic restore_r;
    logic [1:0] src_r;

    assign live_w = {baud_r, thresh_r, txr_en_r, txr_pol_r, txr_on_txd_r};

    hisel_store #(.W(CFG_W)) u_store
    (
        .clk(CLK),
        .bkp_lost(bkp_lost_w),
        .save(CFG_SAVE & ~RST),
        .wdata(live_w),
        .rdata(store_rd),
        .valid(store_valid)
    );

    // Restore one cycle after reset, once read data settled
    always_ff @(posedge CLK)
    begin
        if (RST)
            restore_r <= 1'b1;
        else
            restore_r <= 1'b0;
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            baud_r <= BAUD_DIV_RST;
            thresh_r <= THRESH_RST;
            txr_en_r <= TXR_EN_RST;
            txr_pol_r <= TXR_POL_RST;
            txr_on_txd_r <= 1'b0;
            src_r <= CFG_SRC_DFLT;
        end
        else if (CFG_WR)
        begin
            baud_r <= CFG_BAUD_DIV;
            thresh_r <= CFG_TXR_THRESH;
            txr_en_r <= CFG_TXR_EN;
            txr_pol_r <= CFG_TXR_POL;
            txr_on_txd_r <= CFG_TXR_ON_TXD;
            src_r <= CFG_SRC_LIVE;
        end
        else if (restore_r && store_valid)
        begin
            {baud_r, thresh_r, txr_en_r, txr_pol_r, txr_on_txd_r} <= store_rd;
            src_r <= CFG_SRC_STORE;
        end
    end

    assign BAUD_DIV = baud_r;
    assign CFG_SOURCE = src_r;

    logic cold_r;
    always_ff @(posedge CLK)
    begin
        if (RST)
            cold_r <= 1'b1;
        else if (restore_r)
            cold_r <= ~store_valid;
    end

    assign COLD_START = cold_r;

    // Pop events from link domain, toggle crossing
    logic pop_tgl_l_r;
    always_ff @(posedge LINK_CLK)
    begin
        if (LINK_RST)
            pop_tgl_l_r <= 1'b0;
        else if (LINK_BYTE_POP)
            pop_tgl_l_r <= ~pop_tgl_l_r;
    end

    logic pop_tgl_s;
    hisel_sync #(.W(1)) u_pop_sync
    (
        .clk(CLK),
        .rst(RST),
        .d(pop_tgl_l_r),
        .q(pop_tgl_s)
    );

    logic pop_tgl_d_r;
    logic pop_w;
    assign pop_w = pop_tgl_s ^ pop_tgl_d_r;

    // Buffered output byte count
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic cnt_full_w;
    logic cnt_empty_w;
    assign cnt_full_w = &cnt_r;
    assign cnt_empty_w = (cnt_r == '0);
    assign cnt_nxt = (BYTE_PUSH && !cnt_full_w && !(pop_w && !cnt_empty_w))
                     ? cnt_r + CW'(1) :
                     (pop_w && !cnt_empty_w && !(BYTE_PUSH && !cnt_full_w))
                     ? cnt_r - CW'(1) : cnt_r;

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            cnt_r <= '0;
            pop_tgl_d_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            pop_tgl_d_r <= pop_tgl_s;
        end
    end

    assign TX_COUNT = cnt_r;

    logic pend_w;
    logic txr_lvl_r;
    assign pend_w = txr_en_r && !cnt_empty_w && (cnt_r >= thresh_r);

    always_ff @(posedge CLK)
    begin
        if (RST)
            txr_lvl_r <= ~TXR_POL_RST;
        else
            txr_lvl_r <= pend_w ? txr_pol_r : ~txr_pol_r;
    end

    logic txr_on_txd_w;
    assign txr_on_txd_w = txr_on_txd_r && !serial_w;
    assign TXD_PIN = txr_on_txd_w ? txr_lvl_r : (SER_TXD_DATA | ~serial_w);
    assign TXR_PIN = txr_lvl_r;

    assign SCL_OUT = 1'b0;
    assign SCL_OE = 1'b0;
    assign SDA_OUT = 1'b0;
    assign SDA_OE = serial_w & TWO_WIRE_ACK;

    assign USB_DP_PULLUP = usb_ok_s & main_ok_s;
    assign USB_SELF_POWERED = 1'b1;
    assign USB_FULL_SPEED = 1'b1;

    logic unused_w;
    assign unused_w = sda_s;
endmodule : hisel_top

//--- verification/hisel_host.sv
// Host model: reads buffered bytes over the link while the indicator is active.
// Assumes rdy is the indicator pin set to active-high polarity.
`timescale 1ns/100ps
module hisel_host
(
    // Link side
    input wire logic link_clk,
    input wire logic go,
    input wire logic rdy,
    output logic pop
);
    logic ph_r = 1'h0;
    initial pop = 1'h0;
    always @(posedge link_clk)
    begin
        ph_r <= ~ph_r;
        pop <= go && rdy && ph_r && !pop;
    end
endmodule : hisel_host

//--- verification/hisel_chk_assertions.sv
// Checker for the host interface select block.
// Bound to hisel_top; sees its ports only.
`timescale 1ns/100ps
module hisel_chk
    import hisel_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Watched ports
    input wire logic MAIN_PWR_OK,
    input wire logic BKP_ISOLATE,
    input wire logic RTC_FROM_MAIN,
    input wire logic IF_SEL_N,
    input wire logic [2:0] IF_MODE,
    input wire logic SERIAL_EN,
    input wire logic TWO_WIRE_EN,
    input wire logic FOUR_WIRE_EN,
    input wire logic CFG_WR,
    input wire logic [hisel_pkg::BAUD_W-1:0] CFG_BAUD_DIV,
    input wire logic [hisel_pkg::BAUD_W-1:0] BAUD_DIV,
    input wire logic [1:0] CFG_SOURCE,
    input wire logic SER_TXD_DATA,
    input wire logic TXD_PIN,
    input wire logic TXR_PIN,
    input wire logic SCL_OE,
    input wire logic USB_SELF_POWERED,
    input wire logic USB_FULL_SPEED
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    sequence s_in_rst;
        RST ##1 RST;
    endsequence
    property p_rst;
        disable iff (1'b0) s_in_rst |-> !TXR_PIN && IF_MODE == HISEL_MODE_IDLE
            && CFG_SOURCE == CFG_SRC_DFLT && BAUD_DIV == BAUD_DIV_RST;
    endproperty
    property p_mode;
        $fell(RST) |-> ##[2:6] IF_MODE == (IF_SEL_N ? HISEL_MODE_UART_I2C : HISEL_MODE_SPI);
    endproperty
    property p_excl;
        FOUR_WIRE_EN |-> !SERIAL_EN && !TWO_WIRE_EN;
    endproperty
    property p_pair;
        SERIAL_EN == TWO_WIRE_EN;
    endproperty
    property p_bkp;
        $changed(MAIN_PWR_OK) |-> ##[1:3] BKP_ISOLATE == MAIN_PWR_OK
            && RTC_FROM_MAIN == MAIN_PWR_OK;
    endproperty
    property p_cfg;
        CFG_WR |=> BAUD_DIV == $past(CFG_BAUD_DIV) && CFG_SOURCE == CFG_SRC_LIVE;
    endproperty
    property p_txd;
        SERIAL_EN |-> TXD_PIN == SER_TXD_DATA;
    endproperty
    property p_usb;
        USB_SELF_POWERED && USB_FULL_SPEED;
    endproperty
    property p_scl;
        !SCL_OE;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state");
    a_mode: assert property (p_mode) else $error("strap mode");
    a_excl: assert property (p_excl) else $error("ports overlap");
    a_pair: assert property (p_pair) else $error("serial pair");
    a_bkp: assert property (p_bkp) else $error("backup switch");
    a_cfg: assert property (p_cfg) else $error("live config");
    a_txd: assert property (p_txd) else $error("serial txd");
    a_usb: assert property (p_usb) else $error("usb mode");
    a_scl: assert property (p_scl) else $error("clock driven");
endmodule : hisel_chk

bind hisel_top hisel_chk hisel_chk_inst (.*);

//--- verification/tb.sv
// Self-checking bench for the host interface select block.
// Drives the top ports directly; a host model pops bytes on the link clock.
`timescale 1ns/100ps
module tb;
    import hisel_pkg::*;
    logic CLK, RST, LINK_CLK, LINK_RST, MAIN_PWR_OK, BKP_PWR_OK, RTC_TICK, IF_SEL_N;
    logic CFG_WR, CFG_TXR_EN, CFG_TXR_POL, CFG_TXR_ON_TXD, CFG_SAVE, BYTE_PUSH, go;
    logic LINK_BYTE_POP, SER_TXD_DATA, SDA_IN, TWO_WIRE_ACK, USB_VDD_OK;
    logic BKP_ISOLATE, RTC_FROM_MAIN, COLD_START, SERIAL_EN, TWO_WIRE_EN, FOUR_WIRE_EN;
    logic TXD_PIN, TXR_PIN, SDA_OUT, SDA_OE, SCL_OUT, SCL_OE;
    logic USB_DP_PULLUP, USB_SELF_POWERED, USB_FULL_SPEED;
    logic [1:0] CFG_SOURCE;
    logic [2:0] IF_MODE;
    logic [31:0] RTC_COUNT, c0;
    logic [BAUD_W-1:0] CFG_BAUD_DIV, BAUD_DIV;
    logic [CNT_W-1:0] CFG_TXR_THRESH, TX_COUNT;
    int failures = 0;
    int compares = 0;

    hisel_top hisel_top_inst (.*);
    hisel_host hisel_host_inst (.link_clk(LINK_CLK), .go(go), .rdy(TXR_PIN), .pop(LINK_BYTE_POP));

    always #4 CLK = ~CLK;
    always #62.5 LINK_CLK = ~LINK_CLK;
    always #15259 RTC_TICK = ~RTC_TICK;

    task automatic tick(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask : tick

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            failures++;
            $display("ERROR %s expected %0h seen %0h", n, e, g);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish

    task automatic timeout();
        failures++;
        tally_and_finish();
    endtask : timeout

    task automatic do_rst();
        RST = 1'h1;
        LINK_RST = 1'h1;
        tick(16);
        RST = 1'h0;
        LINK_RST = 1'h0;
        tick(80);
    endtask : do_rst

    task automatic cfg(input logic [15:0] b, input logic [2:0] f, input logic [11:0] th);
        {CFG_BAUD_DIV, CFG_TXR_EN, CFG_TXR_POL, CFG_TXR_ON_TXD, CFG_TXR_THRESH} = {b, f, th};
        CFG_WR = 1'h1;
        tick(1);
        CFG_WR = 1'h0;
        tick(2);
    endtask : cfg

    task automatic push(input int n);
        BYTE_PUSH = 1'h1;
        tick(n);
        BYTE_PUSH = 1'h0;
        tick(3);
    endtask : push

    task automatic wait_txr(input logic v);
        int i;
        for (i = 0; i < 3000 && TXR_PIN !== v; i++)
            tick(1);
        if (i == 3000)
            timeout();
    endtask : wait_txr

    task automatic rtc_rises(input int n);
        logic p;
        p = RTC_TICK;
        for (int i = 0; i < 9999 && n > 0; i++)
        begin
            tick(1);
            n -= (RTC_TICK && !p);
            p = RTC_TICK;
        end
        if (n > 0)
            timeout();
    endtask : rtc_rises

    initial
    begin
        {CLK, LINK_CLK, RTC_TICK, CFG_WR, CFG_SAVE, BYTE_PUSH, go, TWO_WIRE_ACK} = '0;
        {RST, LINK_RST, MAIN_PWR_OK, BKP_PWR_OK, IF_SEL_N, SER_TXD_DATA, SDA_IN} = '1;
        {CFG_BAUD_DIV, CFG_TXR_EN, CFG_TXR_POL, CFG_TXR_ON_TXD, CFG_TXR_THRESH} = '0;
        USB_VDD_OK = 1'h1;
        do_rst();
        push(1);
        chk("mode", HISEL_MODE_UART_I2C, IF_MODE);
        chk("txr_off", 1'h0, TXR_PIN);
        chk("cold", 1'h1, COLD_START);
        chk("src", CFG_SRC_DFLT, CFG_SOURCE);
        chk("baud", BAUD_DIV_RST, BAUD_DIV);
        chk("count", 12'h001, TX_COUNT);
        TWO_WIRE_ACK = 1'h1;
        tick(1);
        chk("ack_oe", 1'h1, SDA_OE);
        chk("sda_low", 1'h0, SDA_OUT);
        $display("test defaults done");
        cfg(16'h0100, 3'h6, 12'h003);
        for (int k = 0; k < 2; k++)
        begin
            push(1);
            chk("level", k, TXR_PIN);
        end
        push(2);
        go = 1'h1;
        wait_txr(1'h0);
        tick(60);
        go = 1'h0;
        chk("drained", 12'h002, TX_COUNT);
        cfg(16'h0100, 3'h4, 12'h003);
        chk("low_idle", 1'h1, TXR_PIN);
        push(1);
        chk("low_act", 1'h0, TXR_PIN);
        $display("test indicator done");
        cfg(16'h1234, 3'h6, 12'h001);
        CFG_SAVE = 1'h1;
        tick(1);
        CFG_SAVE = 1'h0;
        cfg(16'h5678, 3'h2, 12'h001);
        do_rst();
        chk("kept", 16'h1234, BAUD_DIV);
        chk("src", CFG_SRC_STORE, CFG_SOURCE);
        chk("warm", 1'h0, COLD_START);
        $display("test store done");
        IF_SEL_N = 1'h0;
        SER_TXD_DATA = 1'h0;
        do_rst();
        chk("spi", HISEL_MODE_SPI, IF_MODE);
        chk("spi_en", 1'h1, FOUR_WIRE_EN);
        chk("ack_off", 1'h0, SDA_OE);
        cfg(16'h1234, 3'h7, 12'h001);
        chk("txd_idle", 1'h0, TXD_PIN);
        push(1);
        chk("txd_act", 1'h1, TXD_PIN);
        IF_SEL_N = 1'h1;
        $display("test four_wire done");
        MAIN_PWR_OK = 1'h0;
        tick(6);
        chk("on_bkp", 1'h0, BKP_ISOLATE);
        chk("pullup", 1'h0, USB_DP_PULLUP);
        rtc_rises(1);
        tick(5);
        c0 = RTC_COUNT;
        rtc_rises(2);
        tick(5);
        chk("rtc", c0 + 32'h2, RTC_COUNT);
        BKP_PWR_OK = 1'h0;
        tick(6);
        chk("rtc_lost", 32'h0, RTC_COUNT);
        {MAIN_PWR_OK, BKP_PWR_OK} = 2'h3;
        tick(6);
        do_rst();
        chk("cold2", 1'h1, COLD_START);
        chk("dflt", BAUD_DIV_RST, BAUD_DIV);
        $display("test power done");
        tally_and_finish();
    end
endmodule : tb
